// file: design/panel_pkg.sv
/*
 * shared constants for the maintenance panel control block.
 * assumes a single 200 MHz clock and an 8-bit AXI4-Lite byte address.
 */
package panel_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int DEBOUNCE_NS = 1000000;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BCOUNT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RECLEN = 8'h0C;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  localparam logic [7:0] OFS_ERR_CAP = 8'h18;
  localparam logic [7:0] OFS_PANEL_REG = 8'h1C;
  // ctrl bits
  localparam int CTRL_START = 0;
  localparam int CTRL_RST_CMP = 1;
  localparam int CTRL_RST_ERR = 2;
  localparam int CTRL_CMP_SYNC = 3;
  // interrupt bits
  localparam int INT_SENSE_DONE = 0;
  localparam int INT_HALT = 1;
  localparam int INT_TRAP = 2;
  localparam int INT_DF_ERR = 3;
  localparam int INT_W = 4;
  // ----------------------------------------
  // reset values and addresses
  // ----------------------------------------
  localparam logic [11:0] BCOUNT_RST = 12'h000;
  localparam logic [11:0] IDLE_ADDR = 12'h7FF;
  localparam logic [11:0] SENSE_ADDR = 12'h20A;
  localparam logic [11:0] TRAP_ADDR = 12'h000;
  localparam logic [4:0] SENSE_BYTES = 5'h18;
  // ----------------------------------------
  // byte count to record length
  // ----------------------------------------
  localparam logic [11:0] BC_FF0 = 12'hFF0;
  localparam logic [11:0] BC_000 = 12'h000;
  localparam logic [11:0] BC_010 = 12'h010;
  localparam logic [11:0] BC_001 = 12'h001;
  localparam logic [11:0] BC_042 = 12'h042;
  localparam logic [11:0] LEN_FF0 = 12'h002;
  localparam logic [11:0] LEN_000 = 12'h003;
  localparam logic [11:0] LEN_010 = 12'h004;
  localparam logic [11:0] LEN_001 = 12'h403;
  localparam logic [11:0] LEN_042 = 12'h807;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_STOP = 2'b01,
    MODE_INSN = 2'b10,
    MODE_ALT = 2'b11
  } store_mode_type;
  typedef enum logic [1:0] {
    SNS_IDLE = 2'b00,
    SNS_PRESENT = 2'b01,
    SNS_DONE = 2'b10
  } sense_state_type;
endpackage

// file: design/switch_debounce.sv
/*
 * synchroniser and debouncer for one momentary panel switch.
 * assumes a mechanical contact that bounces for less than the hold time.
 */
module switch_debounce #(
  parameter int HOLD_CYC = 16
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // sync reset, low
  input wire logic raw, // switch contact
  output logic level, // debounced level
  output logic rise // one-cycle press pulse
);
  logic s1_q, s2_q, lvl_q, lvl_d;
  logic [31:0] cnt_q, cnt_d;
  wire differ = s2_q != lvl_q;
  wire stable = cnt_q >= 32'(HOLD_CYC - 1);

  // ----------------------------------------
  // bounce filter
  // ----------------------------------------
  // only a level that holds for the full time is taken, so chatter never
  // yields a second press
  assign cnt_d = differ ? (stable ? 32'h0000_0000 : cnt_q + 32'h0000_0001) : 32'h0000_0000;
  assign lvl_d = (differ && stable) ? s2_q : lvl_q;
  assign level = lvl_q;
  assign rise = differ && stable && s2_q;

  // two flops, then the filter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      lvl_q <= 1'b0;
      cnt_q <= 32'h0000_0000;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
    end
  end

  AST_ONE_PRESS: assert property (@(posedge mclk) disable iff (!rst_n)
    rise |=> !rise) else $error("press pulse longer than one cycle");
endmodule

// file: design/record_length.sv
/*
 * maps the byte count register onto the written test record length.
 * assumes a purely combinational use; other counts give the short record.
 */
module record_length
  import panel_pkg::*;
(
  input wire logic [11:0] bcount, // byte count value
  output logic [11:0] length // record length in bytes
);
  // ----------------------------------------
  // length table
  // ----------------------------------------
  always_comb begin
    case (bcount)
      BC_FF0: length = LEN_FF0;
      BC_010: length = LEN_010;
      BC_001: length = LEN_001;
      BC_042: length = LEN_042;
      default: length = LEN_000;
    endcase
  end
endmodule

// file: design/maintenance_panel_control.sv
/*
 * maintenance panel control: panel enable, mode set switch, stop and
 * trap gating, sense byte stepping, test record length, density choice.
 * assumes panel pins are asynchronous and processor events share mclk.
 */
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
module maintenance_panel_control
  import panel_pkg::*;
#(
  parameter int DEBOUNCE = DEBOUNCE_CYC
) (
  input wire logic mclk, // 200 MHz clock
  input wire logic rst_n, // sync reset, low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // response valid
  input wire logic s_axi_bready, // response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic panel_enable_sw, // panel enable toggle
  input wire logic check_stop_sw, // control check stop
  input wire logic cmp_stop_sw, // compare stop
  input wire logic multi_step_sw, // multi vs single
  input wire logic disp_counter_sw, // counter displayed
  input wire logic gap_jumper, // loop write read gap jumper
  input wire logic load_point, // tape at load point
  input wire logic entry_cmp_sw, // down loads compare reg
  input wire logic [1:0] store_mode_sw, // mode selector
  input wire logic [11:0] data_entry_sw, // data entry
  input wire logic start_step_sw, // start or step
  input wire logic set_up_sw, // three-way switch up
  input wire logic set_down_sw, // three-way switch down
  input wire logic hw_err, // processor hardware error
  input wire logic ctl_check, // control check seen
  input wire logic storage_init, // local storage ready
  input wire logic df_err, // data flow error
  input wire logic [7:0] cmd_code, // current command
  input wire logic addr_cmp_eq, // compare hit
  input wire logic tape_write, // write op done
  input wire logic [7:0] sense_byte_in, // sense byte at index
  output logic panel_lamp, // enable lamp
  output logic [11:0] first_mp_addr, // first processor addr
  output logic [4:0] sense_idx, // sense byte index
  output logic [7:0] bus_in, // inbound bus display
  output logic trap_req, // trap to 000
  output logic proc_halt, // processors stopped
  output logic cmp_stop, // compare stop
  output logic counter_set_ok, // counter set allowed
  output logic cmp_sync, // compare sync pulse
  output logic restart_cmp, // restart on compare
  output logic restart_err, // restart on error
  output logic density_6250, // high density mode
  output logic [1:0] store_mode, // loaded store mode
  output logic [11:0] panel_reg, // maintenance register
  output logic [11:0] cmpr_reg, // compare register
  output logic [11:0] rec_len, // test record length
  output logic irq // interrupt level
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int NSYNC = 22;
  logic [NSYNC-1:0] pins_raw, s1_q, s2_q;
  assign pins_raw = {panel_enable_sw, check_stop_sw, cmp_stop_sw, multi_step_sw, disp_counter_sw, gap_jumper,
    load_point, entry_cmp_sw, store_mode_sw, data_entry_sw};
  // one generate loop, first flop feeds only the second
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pins_raw[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end
  wire p_en = s2_q[21];
  wire p_cstop = s2_q[20];
  wire p_cmp = s2_q[19];
  wire p_multi = s2_q[18];
  wire p_disp = s2_q[17];
  wire p_jump = s2_q[16];
  wire p_lp = s2_q[15];
  wire p_ecmp = s2_q[14];
  wire [1:0] p_mode = s2_q[13:12];
  wire [11:0] p_data = s2_q[11:0];

  logic step_p, up_p, down_p;
  switch_debounce #(.HOLD_CYC(DEBOUNCE)) u_step (.mclk(mclk), .rst_n(rst_n),
    .raw(start_step_sw), .level(), .rise(step_p));
  switch_debounce #(.HOLD_CYC(DEBOUNCE)) u_up (.mclk(mclk), .rst_n(rst_n),
    .raw(set_up_sw), .level(), .rise(up_p));
  switch_debounce #(.HOLD_CYC(DEBOUNCE)) u_down (.mclk(mclk), .rst_n(rst_n),
    .raw(set_down_sw), .level(), .rise(down_p));

  // ----------------------------------------
  // register file state
  // ----------------------------------------
  logic [3:0] ctrl_q;
  logic [11:0] bcount_q;
  logic [INT_W-1:0] ist_q, imask_q;
  logic [19:0] err_cap_q;
  logic [11:0] len_w;
  record_length u_len (.bcount(bcount_q), .length(len_w));
  // ----------------------------------------
  // panel enable and function gating
  // ----------------------------------------
  // enable takes effect whenever the switch moves, no idle needed
  wire cstop_on = p_en && p_cstop;
  wire fn_ok = p_en && !p_cstop;
  store_mode_type mode_q;
  wire mode_stop = mode_q == MODE_STOP;
  // check stop blocks the trap; it halts on hw_err in stop mode, or on a control check with storage not ready
  wire trap_d = hw_err && !cstop_on;
  wire halt_ev = cstop_on && ((hw_err && mode_stop) || (ctl_check && !storage_init));
  // ----------------------------------------
  // sense stepping
  // ----------------------------------------
  sense_state_type st_q, st_d;
  logic [4:0] idx_q;
  // jumper cuts the sense short by an amount tied to the byte count
  wire [4:0] limit = p_jump ? {1'b0, bcount_q[3:0]} + 5'h01 : SENSE_BYTES;
  logic ctrl_wr_start;
  wire start_p = (ctrl_wr_start) || (step_p && st_q != SNS_PRESENT);
  wire adv = st_q == SNS_PRESENT && step_p && p_disp;
  wire last = idx_q + 5'h01 >= limit;

  always_comb begin
    st_d = st_q;
    case (st_q)
      SNS_IDLE: if (start_p) st_d = SNS_PRESENT;
      SNS_PRESENT: if (adv && last) st_d = p_multi ? SNS_IDLE : SNS_DONE;
      SNS_DONE: if (start_p) st_d = SNS_PRESENT;
      default: st_d = SNS_IDLE;
    endcase
  end

  // sense sequencer and address display
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= SNS_IDLE;
      idx_q <= 5'h00;
      first_mp_addr <= IDLE_ADDR;
    end else begin
      st_q <= st_d;
      if (start_p && st_q != SNS_PRESENT) idx_q <= 5'h00;
      else if (adv && !last) idx_q <= idx_q + 5'h01;
      if (trap_d) first_mp_addr <= TRAP_ADDR;
      else if (st_d == SNS_PRESENT) first_mp_addr <= SENSE_ADDR;
      else if (st_d == SNS_IDLE) first_mp_addr <= IDLE_ADDR;
    end
  end
  assign sense_idx = idx_q;

  // ----------------------------------------
  // panel outputs
  // ----------------------------------------
  logic off_lp_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      panel_lamp <= 1'b0;
      bus_in <= 8'h00;
      trap_req <= 1'b0;
      proc_halt <= 1'b0;
      cmp_stop <= 1'b0;
      counter_set_ok <= 1'b0;
      cmp_sync <= 1'b0;
      restart_cmp <= 1'b0;
      restart_err <= 1'b0;
      off_lp_q <= 1'b0;
      mode_q <= MODE_NORMAL;
      panel_reg <= 12'h000;
      cmpr_reg <= 12'h000;
      err_cap_q <= 20'h0_0000;
    end else begin
      panel_lamp <= p_en;
      bus_in <= sense_byte_in;
      trap_req <= trap_d;
      if (halt_ev) proc_halt <= 1'b1;
      else if (start_p) proc_halt <= 1'b0;
      cmp_stop <= fn_ok && p_cmp && addr_cmp_eq;
      counter_set_ok <= fn_ok;
      cmp_sync <= fn_ok && ctrl_q[CTRL_CMP_SYNC] && addr_cmp_eq;
      restart_cmp <= fn_ok && ctrl_q[CTRL_RST_CMP] && addr_cmp_eq;
      restart_err <= fn_ok && ctrl_q[CTRL_RST_ERR] && hw_err;
      // rewind to load point drops back to low density
      if (p_lp) off_lp_q <= 1'b0;
      else if (tape_write) off_lp_q <= 1'b1;
      if (up_p) mode_q <= store_mode_type'(p_mode);
      if (down_p && p_ecmp) cmpr_reg <= p_data;
      else if (down_p) panel_reg <= p_data;
      if (df_err) err_cap_q <= {cmd_code, bcount_q};
    end
  end
  assign density_6250 = off_lp_q && !p_lp;
  assign store_mode = mode_q;
  assign rec_len = len_w;
  assign irq = |(ist_q & imask_q);
  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic aw_q, w_q, bv_q, rv_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q, rd_q;
  logic [3:0] ws_q;
  logic [1:0] br_q, rr_q;
  wire do_wr = aw_q && w_q && !bv_q;
  wire [31:0] wmask;
  // byte strobes widened to a bit mask, one lane per loop pass
  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign wmask[b*8 +: 8] = {8{ws_q[b]}};
  end
  wire [31:0] wv = wd_q & wmask;
  wire hit_ctrl = awa_q == OFS_CTRL;
  wire hit_bc = awa_q == OFS_BCOUNT;
  wire hit_is = awa_q == OFS_INT_STAT;
  wire hit_im = awa_q == OFS_INT_MASK;
  wire wr_ok = hit_ctrl || hit_bc || hit_is || hit_im;
  assign ctrl_wr_start = do_wr && hit_ctrl && wv[CTRL_START];
  wire [INT_W-1:0] ev = {df_err, trap_d, halt_ev, adv && last};
  // a new event wins over a write-one clear in the same cycle
  wire [INT_W-1:0] ist_d = (ist_q & ~((do_wr && hit_is) ? wv[INT_W-1:0] : {INT_W{1'b0}})) | ev;
  // read decode
  logic [31:0] rmux;
  logic rhit;
  always_comb begin
    rhit = 1'b1;
    if (s_axi_araddr == OFS_CTRL) rmux = {28'h000_0000, ctrl_q};
    else if (s_axi_araddr == OFS_BCOUNT) rmux = {20'h0_0000, bcount_q};
    else if (s_axi_araddr == OFS_STATUS) rmux = {19'h0_0000, mode_q,
      st_q, idx_q, density_6250, proc_halt, cstop_on, p_en};
    else if (s_axi_araddr == OFS_RECLEN) rmux = {20'h0_0000, len_w};
    else if (s_axi_araddr == OFS_INT_STAT) rmux = {28'h000_0000, ist_q};
    else if (s_axi_araddr == OFS_INT_MASK) rmux = {28'h000_0000, imask_q};
    else if (s_axi_araddr == OFS_ERR_CAP) rmux = {12'h000, err_cap_q};
    else if (s_axi_araddr == OFS_PANEL_REG) rmux = {8'h00, cmpr_reg, panel_reg};
    else begin
      rmux = 32'h0000_0000;
      rhit = 1'b0;
    end
  end

  // address and data are taken in either order, one write in flight
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      br_q <= 2'b00;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bv_q <= 1'b1;
        br_q <= wr_ok ? 2'b00 : 2'b10;
      end else if (bv_q && s_axi_bready) bv_q <= 1'b0;
    end
  end

  // read answer, registered
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rv_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      rr_q <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rv_q <= 1'b1;
      rd_q <= rmux;
      rr_q <= rhit ? 2'b00 : 2'b10;
    end else if (rv_q && s_axi_rready) rv_q <= 1'b0;
  end

  // software registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= 4'h0;
      bcount_q <= BCOUNT_RST;
      ist_q <= {INT_W{1'b0}};
      imask_q <= {INT_W{1'b0}};
    end else begin
      ist_q <= ist_d;
      if (do_wr && hit_ctrl) ctrl_q <= {wv[3:1], 1'b0};
      if (do_wr && hit_bc) bcount_q <= wv[11:0];
      if (do_wr && hit_im) imask_q <= wv[INT_W-1:0];
    end
  end
  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready = !w_q && !bv_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_IDLE_7FF: assert property (@(posedge mclk) disable iff (!rst_n)
    (adv && last && p_multi && !trap_d) |=> first_mp_addr == IDLE_ADDR)
    else $error("no return to idle address after last sense byte");
  AST_STEP_ONE: assert property (@(posedge mclk) disable iff (!rst_n)
    (adv && !last) |=> idx_q == $past(idx_q) + 5'h01)
    else $error("sense index did not advance by one");
  AST_LEN_001: assert property (@(posedge mclk) disable iff (!rst_n)
    bcount_q == BC_001 |-> rec_len == 12'h403)
    else $error("record length wrong for count 001");
  AST_JUMP_LIM: assert property (@(posedge mclk) disable iff (!rst_n)
    idx_q < limit || st_q != SNS_PRESENT)
    else $error("sense index beyond its limit");
  AST_HALT: assert property (@(posedge mclk) disable iff (!rst_n)
    (cstop_on && ctl_check && !storage_init) |=> proc_halt)
    else $error("uninitialised storage check did not halt");
  AST_NO_TRAP: assert property (@(posedge mclk) disable iff (!rst_n)
    (cstop_on && !mode_stop && !(ctl_check && !storage_init)) |=> !trap_req && !($rose(proc_halt)))
    else $error("trap or halt under check stop alone");
  AST_INHIBIT: assert property (@(posedge mclk) disable iff (!rst_n)
    cstop_on |=> !cmp_stop && !counter_set_ok && !cmp_sync && !restart_cmp && !restart_err)
    else $error("function not inhibited by check stop");
  AST_LOW_DENS: assert property (@(posedge mclk) disable iff (!rst_n)
    p_lp |=> !density_6250) else $error("high density at load point");
  AST_HIGH_DENS: assert property (@(posedge mclk) disable iff (!rst_n)
    (tape_write && !p_lp) ##1 !p_lp |-> density_6250)
    else $error("no high density after write");
  AST_LAMP: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(p_en) |=> panel_lamp) else $error("lamp did not follow enable");
endmodule

// file: verification/panel_operator.sv
/*
 * partner model: the engineer working the momentary panel switches.
 * assumes one press request at a time, given as a one-cycle pulse.
 */
module panel_operator (
  input wire logic mclk, // clock
  input wire logic [2:0] press, // request: up, down, step
  output logic [2:0] sw, // raw contacts
  output logic busy // press under way
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] sel_q = 3'b000;
  logic [5:0] cnt_q = 6'd0;
  assign busy = cnt_q != 6'd0;
  // contacts chatter on make, then hold, then open; chatter is shorter than the debounce
  assign sw = (cnt_q > 6'd25) ? (cnt_q[0] ? sel_q : 3'b000) : ((cnt_q > 6'd8) ? sel_q : 3'b000);
  always @(posedge mclk) begin
    if (cnt_q == 6'd0) begin
      sel_q <= press;
      cnt_q <= (press != 3'b000) ? 6'd30 : 6'd0;
    end else begin
      cnt_q <= cnt_q - 6'd1;
    end
  end
endmodule

// file: verification/tb_maintenance_panel_control.sv
/*
 * self-checking bench for the maintenance panel control block.
 * assumes the design's debounce count is cut to 4 for simulation.
 */
module tb_maintenance_panel_control;
  timeunit 1ns;
  timeprecision 100ps;
  import panel_pkg::*;
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, cmd_code = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic panel_enable_sw = 0, check_stop_sw = 0, cmp_stop_sw = 0, multi_step_sw = 0, disp_counter_sw = 0;
  logic gap_jumper = 0, load_point = 0, entry_cmp_sw = 0, storage_init = 1;
  logic [1:0] store_mode_sw = 2'b00;
  logic [11:0] data_entry_sw = 12'h000;
  logic [4:0] ev = 5'h00;
  logic [2:0] press = 3'b000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
  logic [1:0] s_axi_bresp, s_axi_rresp, store_mode, resp;
  logic [31:0] s_axi_rdata, rd;
  logic start_step_sw, set_up_sw, set_down_sw, hw_err, ctl_check, df_err, addr_cmp_eq, tape_write;
  logic panel_lamp, trap_req, proc_halt, cmp_stop, counter_set_ok, cmp_sync, restart_cmp, restart_err;
  logic density_6250, irq;
  logic [7:0] sense_byte_in, bus_in;
  logic [11:0] first_mp_addr, panel_reg, cmpr_reg, rec_len;
  logic [4:0] sense_idx;
  logic [11:0] bc[5] = '{BC_FF0, BC_000, BC_010, BC_001, BC_042};
  logic [11:0] ln[5] = '{LEN_FF0, LEN_000, LEN_010, LEN_001, LEN_042};
  int err_count = 0;
  int n_tests = 0;
  int k;
  // one-cycle event pulses share one vector so a single task can fire any of them
  assign {tape_write, addr_cmp_eq, df_err, ctl_check, hw_err} = ev;
  assign sense_byte_in = {3'b010, sense_idx};
  maintenance_panel_control #(.DEBOUNCE(4)) dut_u (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .panel_enable_sw, .check_stop_sw, .cmp_stop_sw, .multi_step_sw, .disp_counter_sw, .gap_jumper, .load_point,
    .entry_cmp_sw, .store_mode_sw, .data_entry_sw, .start_step_sw, .set_up_sw, .set_down_sw, .hw_err, .ctl_check,
    .storage_init, .df_err, .cmd_code, .addr_cmp_eq, .tape_write, .sense_byte_in, .panel_lamp, .first_mp_addr,
    .sense_idx, .bus_in, .trap_req, .proc_halt, .cmp_stop, .counter_set_ok, .cmp_sync, .restart_cmp, .restart_err,
    .density_6250, .store_mode, .panel_reg, .cmpr_reg, .rec_len, .irq);
  panel_operator op_u (.mclk(mclk), .press(press), .sw({set_up_sw, set_down_sw, start_step_sw}), .busy(busy));
  initial forever #2.5 mclk = ~mclk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test;
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic lim(input int i);
    if (i >= 60) begin
      err_count++;
      $display("wrong value wait exp done got timeout");
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 60 && s_axi_bvalid !== 1'b1; i++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    lim(i);
  endtask
  task automatic rdr(input logic [7:0] a);
    int i;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 60 && s_axi_rvalid !== 1'b1; i++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    lim(i);
  endtask
  // a press lasts about 30 cycles; the check waits for the contacts to open
  task automatic push(input logic [2:0] m);
    int i;
    @(posedge mclk);
    press <= m;
    @(posedge mclk);
    press <= 3'b000;
    #1;
    for (i = 0; i < 60 && busy; i++) @(posedge mclk);
    #1;
    lim(i);
  endtask
  // level switches pass two sync flops and a register
  task automatic settle;
    repeat (6) @(posedge mclk);
    #1;
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 5'h00;
    #1;
  endtask
  task automatic sense(input int n);
    wr(OFS_CTRL, 32'h0000_0001);
    settle();
    `CHK("addr", SENSE_ADDR, first_mp_addr)
    for (k = 1; k < n; k++) begin
      push(3'b001);
      `CHK("idx", k[4:0], sense_idx)
      `CHK("bus", {3'b010, k[4:0]}, bus_in)
    end
    push(3'b001);
    `CHK("addr", IDLE_ADDR, first_mp_addr)
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    `CHK("addr", IDLE_ADDR, first_mp_addr)
    `CHK("reclen", LEN_000, rec_len)
    for (k = 0; k < 5; k++) begin
      wr(OFS_BCOUNT, {20'h0_0000, bc[k]});
      rdr(OFS_RECLEN);
      `CHK("reclen", {20'h0_0000, ln[k]}, rd)
    end
    wr(8'h40, 32'h0000_0001);
    `CHK("bresp", 2'b10, resp)
    rdr(8'h40);
    `CHK("rresp", 2'b10, resp)
    `CHK("rdata", 32'h0000_0000, rd)
    @(posedge mclk);
    panel_enable_sw <= 1'b1;
    store_mode_sw <= MODE_INSN;
    data_entry_sw <= 12'hABC;
    settle();
    `CHK("lamp", 1'b1, panel_lamp)
    push(3'b100);
    `CHK("mode", MODE_INSN, store_mode)
    push(3'b010);
    `CHK("panel", 12'hABC, panel_reg)
    entry_cmp_sw <= 1'b1;
    data_entry_sw <= 12'h20A;
    store_mode_sw <= MODE_NORMAL;
    settle();
    push(3'b010);
    `CHK("cmpr", 12'h20A, cmpr_reg)
    push(3'b100);
    `CHK("mode", MODE_NORMAL, store_mode)
    wr(OFS_INT_MASK, 32'h0000_0004);
    pulse(5'h01);
    `CHK("trap", 1'b1, trap_req)
    settle();
    `CHK("irq", 1'b1, irq)
    wr(OFS_INT_STAT, 32'h0000_0004);
    settle();
    `CHK("irq", 1'b0, irq)
    check_stop_sw <= 1'b1;
    cmp_stop_sw <= 1'b1;
    settle();
    pulse(5'h01);
    `CHK("trap", 1'b0, trap_req)
    `CHK("halt", 1'b0, proc_halt)
    rdr(OFS_STATUS);
    `CHK("chkstop", 1'b1, rd[1])
    wr(OFS_CTRL, 32'h0000_000E);
    pulse(5'h09);
    `CHK("rcmp", 1'b0, restart_cmp)
    `CHK("rerr", 1'b0, restart_err)
    `CHK("trap", 1'b0, trap_req)
    `CHK("sync", 1'b0, cmp_sync)
    `CHK("cstop", 1'b0, cmp_stop)
    `CHK("icset", 1'b0, counter_set_ok)
    check_stop_sw <= 1'b0;
    settle();
    pulse(5'h09);
    `CHK("rcmp", 1'b1, restart_cmp)
    `CHK("sync", 1'b1, cmp_sync)
    `CHK("cstop", 1'b1, cmp_stop)
    `CHK("rerr", 1'b1, restart_err)
    `CHK("icset", 1'b1, counter_set_ok)
    check_stop_sw <= 1'b1;
    storage_init <= 1'b0;
    settle();
    pulse(5'h02);
    `CHK("halt", 1'b1, proc_halt)
    check_stop_sw <= 1'b0;
    storage_init <= 1'b1;
    cmd_code <= 8'h5A;
    settle();
    pulse(5'h04);
    rdr(OFS_ERR_CAP);
    `CHK("errcap", 8'h5A, rd[19:12])
    load_point <= 1'b1;
    settle();
    pulse(5'h10);
    `CHK("dens", 1'b0, density_6250)
    load_point <= 1'b0;
    settle();
    pulse(5'h10);
    `CHK("dens", 1'b1, density_6250)
    multi_step_sw <= 1'b1;
    disp_counter_sw <= 1'b1;
    settle();
    sense(24);
    gap_jumper <= 1'b1;
    wr(OFS_BCOUNT, 32'h0000_0003);
    settle();
    sense(4);
    finish_test();
  end
  initial begin
    #250000;
    err_count++;
    finish_test();
  end
endmodule
